// ===== swr_pkg.sv
// shared constants and types for the single-wire rom select layer
// Operation
// - read-identity 33h: family, serial, crc out
// - match 55h: 64 bits all equal own
// - identity mismatch: passive until next reset
// - skip CCh: straight to device commands
// - resume A5h: proceed only if resume_flag set
// - resume_flag set by match, search, overdrive-match
// - other device selected clears resume_flag
// - overdrive-skip 3Ch sets overdrive_flag, proceeds
// - reset of 480us clears overdrive_flag
// - overdrive-match 69h: enter overdrive, then match at fast speed
// - overdrive kept when overdrive-match misses only if already fast before
// - master resets fast then addresses one
// - search F0h: bit, complement, master choice
// - all fields shifted least significant first
// - master makes all falls except presence
// - overdrive flag selects fast device timing; master speed is set by fast_i per request
// - slot timer starts at low crossing
// - master honours write-one and write-zero lows
// - read zero pulls low, one leaves released
// - master samples in window, waits slot_period
// - recovery interval before next slot
// - receiver filters rising-edge glitches
// - holdoff restarts on early low, else slot
package swr_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam logic [7:0] CMD_READ     = 8'h33;
  localparam logic [7:0] CMD_MATCH    = 8'h55;
  localparam logic [7:0] CMD_SKIP     = 8'hCC;
  localparam logic [7:0] CMD_RESUME   = 8'hA5;
  localparam logic [7:0] CMD_OD_SKIP  = 8'h3C;
  localparam logic [7:0] CMD_OD_MATCH = 8'h69;
  localparam logic [7:0] CMD_SEARCH   = 8'hF0;
  localparam int unsigned ID_BITS = 64;
  // times in ns
  localparam int unsigned RESET_STD_NS = 480000;
  localparam int unsigned RESET_OD_NS  = 48000;
  localparam int unsigned PRES_WAIT_STD_NS = 30000;
  localparam int unsigned PRES_WAIT_OD_NS  = 3000;
  localparam int unsigned PRES_LOW_STD_NS  = 120000;
  localparam int unsigned PRES_LOW_OD_NS   = 12000;
  localparam int unsigned SAMPLE_STD_NS = 30000;
  localparam int unsigned SAMPLE_OD_NS  = 3000;
  localparam int unsigned READ_LOW_STD_NS = 30000;
  localparam int unsigned READ_LOW_OD_NS  = 3000;
  localparam int unsigned WRITE_ONE_LOW_STD_NS  = 6000;
  localparam int unsigned WRITE_ONE_LOW_OD_NS   = 1000;
  localparam int unsigned WRITE_ZERO_LOW_STD_NS = 60000;
  localparam int unsigned WRITE_ZERO_LOW_OD_NS  = 7000;
  localparam int unsigned SLOT_STD_NS = 70000;
  localparam int unsigned SLOT_OD_NS  = 10000;
  localparam int unsigned RECOVERY_STD_NS = 5000;
  localparam int unsigned RECOVERY_OD_NS  = 2000;
  localparam int unsigned RESET_LOW_STD_NS = 500000;
  localparam int unsigned RESET_LOW_OD_NS  = 70000;
  localparam int unsigned RISING_HOLDOFF_NS = 100;
  // counts in cycles: minima rounded up
  localparam int unsigned RESET_STD_CYC = (RESET_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RESET_OD_CYC  = (RESET_OD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PRES_WAIT_STD_CYC = (PRES_WAIT_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PRES_WAIT_OD_CYC  = (PRES_WAIT_OD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PRES_LOW_STD_CYC  = (PRES_LOW_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PRES_LOW_OD_CYC   = (PRES_LOW_OD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SAMPLE_STD_CYC = (SAMPLE_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SAMPLE_OD_CYC  = (SAMPLE_OD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned READ_LOW_STD_CYC = (READ_LOW_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned READ_LOW_OD_CYC  = (READ_LOW_OD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned W1_STD_CYC = (WRITE_ONE_LOW_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned W1_OD_CYC  = (WRITE_ONE_LOW_OD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned W0_STD_CYC = (WRITE_ZERO_LOW_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned W0_OD_CYC  = (WRITE_ZERO_LOW_OD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLOT_STD_CYC = (SLOT_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLOT_OD_CYC  = (SLOT_OD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REC_STD_CYC = (RECOVERY_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned REC_OD_CYC  = (RECOVERY_OD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RSTLOW_STD_CYC = (RESET_LOW_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RSTLOW_OD_CYC  = (RESET_LOW_OD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLDOFF_CYC = (RISING_HOLDOFF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 17;
  typedef enum logic [2:0] {
    SWR_REQ_RESET,
    SWR_REQ_WRITE0,
    SWR_REQ_WRITE1,
    SWR_REQ_READ
  } swr_req_t;
endpackage

// ===== swr_if.sv
// single-wire line carrier joining device and master ends
`timescale 1ns/1ps
interface swr_if;
  logic dev_line_o;
  logic dev_line_oe;
  logic mst_line_o;
  logic mst_line_oe;
  logic line;
  // wired-and with pull-up: any enabled driver driving zero pulls low
  assign line = !((dev_line_oe && !dev_line_o) || (mst_line_oe && !mst_line_o));
  modport device (input line, output dev_line_o, output dev_line_oe);
  modport master (input line, output mst_line_o, output mst_line_oe);
endinterface

// ===== swr_line_filter.sv
// receiver front end with rising-edge hold-off
`timescale 1ns/1ps
module swr_line_filter
  import swr_pkg::*;
#(
  parameter int unsigned HOLD = HOLDOFF_CYC
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  input  wire logic line_i,
  output logic      level_o,
  output logic      fall_o
);
  import swr_pkg::*;
  logic [7:0] hold_cnt;
  // high seen only after it has stayed high for HOLD cycles
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hold_cnt <= 8'h00;
      level_o  <= 1'b1;
      fall_o   <= 1'b0;
    end else begin
      fall_o <= 1'b0;
      if (!line_i) begin
        hold_cnt <= 8'h00;
        if (level_o) begin
          level_o <= 1'b0;
          fall_o  <= 1'b1;
        end
      end else if (!level_o) begin
        if (hold_cnt >= 8'(HOLD - 1)) begin
          level_o <= 1'b1;
        end else begin
          hold_cnt <= hold_cnt + 8'h01;
        end
      end
    end
  end
endmodule

// ===== swr_device.sv
// slave end: reset/presence, bit slots and rom-level selection
`timescale 1ns/1ps
module swr_device
  import swr_pkg::*;
#(
  parameter logic [63:0] IDENTITY = 64'h0123_4567_89AB_CD10 // arbitrary value
) (
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  swr_if.device     bus,
  output logic      selected_o,
  output logic      overdrive_o,
  output logic      resume_o,
  output logic [7:0] data_o,
  output logic      data_valid_o
);
  import swr_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_READ_ID, ST_MATCH, ST_SEARCH, ST_SELECTED, ST_PASSIVE
  } swr_dev_state_t;

  typedef enum logic [1:0] {
    SL_IDLE, SL_LOW, SL_PRES_WAIT, SL_PRES
  } swr_slot_state_t;

  logic           level;
  logic           fall;
  swr_dev_state_t state;
  swr_slot_state_t sl;
  logic [CNT_W-1:0] tmr;
  logic [CNT_W-1:0] low_cnt;
  logic           od;
  logic           od_match_pending;
  logic           rc;
  logic [7:0]     shreg;
  logic [6:0]     bitn;
  logic [1:0]     phase;
  logic           bit_done;
  logic           bit_val;
  logic           reset_seen;
  logic           long_reset;
  logic           tx_zero;
  logic [7:0]     cmd_next;

  swr_line_filter #(.HOLD(HOLDOFF_CYC)) u_filt (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .line_i     (bus.line),
    .level_o    (level),
    .fall_o     (fall)
  );

  ////////////////////////////////////////////////////////////////////////
  // slot engine: timer from each low crossing
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sl         <= SL_IDLE;
      tmr        <= '0;
      low_cnt    <= '0;
      bit_done   <= 1'b0;
      bit_val    <= 1'b0;
      reset_seen <= 1'b0;
      long_reset <= 1'b0;
      bus.dev_line_o  <= 1'b0;
      bus.dev_line_oe <= 1'b0;
    end else begin
      bit_done   <= 1'b0;
      reset_seen <= 1'b0;
      tmr        <= tmr + 1'b1;
      case (sl)
        SL_IDLE: begin
          if (fall) begin
            sl      <= SL_LOW;
            tmr     <= '0;
            low_cnt <= '0;
            bus.dev_line_oe <= tx_zero;
          end
        end
        SL_LOW: begin
          if (!level) begin
            low_cnt <= low_cnt + 1'b1;
          end
          // sample point chosen by slot timer and speed
          if (tmr == CNT_W'(od ? SAMPLE_OD_CYC : SAMPLE_STD_CYC)) begin
            bit_val <= level;
          end
          if (tmr == CNT_W'(od ? READ_LOW_OD_CYC : READ_LOW_STD_CYC)) begin
            bus.dev_line_oe <= 1'b0;
          end
          if (level && tmr > CNT_W'(od ? READ_LOW_OD_CYC : READ_LOW_STD_CYC)) begin
            sl <= SL_IDLE;
            if (low_cnt >= CNT_W'(od ? RESET_OD_CYC : RESET_STD_CYC)) begin
              sl         <= SL_PRES_WAIT;
              tmr        <= '0;
              reset_seen <= 1'b1;
              long_reset <= low_cnt >= CNT_W'(RESET_STD_CYC);
            end else begin
              bit_done <= 1'b1;
            end
          end
        end
        SL_PRES_WAIT: begin
          if (tmr == CNT_W'(od ? PRES_WAIT_OD_CYC : PRES_WAIT_STD_CYC)) begin
            sl  <= SL_PRES;
            tmr <= '0;
            bus.dev_line_oe <= 1'b1;
          end
        end
        SL_PRES: begin
          if (tmr == CNT_W'(od ? PRES_LOW_OD_CYC : PRES_LOW_STD_CYC)) begin
            sl <= SL_IDLE;
            bus.dev_line_oe <= 1'b0;
          end
        end
        default: sl <= SL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit to drive in the coming read slot
  always_comb begin
    tx_zero = 1'b0;
    case (state)
      ST_READ_ID: tx_zero = !IDENTITY[bitn[5:0]];
      ST_SEARCH: begin
        if (phase == 2'd0) tx_zero = !IDENTITY[bitn[5:0]];
        else if (phase == 2'd1) tx_zero = IDENTITY[bitn[5:0]];
      end
      default: tx_zero = 1'b0;
    endcase
  end

  assign cmd_next = {bit_val, shreg[7:1]};

  ////////////////////////////////////////////////////////////////////////
  // rom-level command layer
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
      shreg <= 8'h00;
      bitn  <= 7'd0;
      phase <= 2'd0;
      od    <= 1'b0;
      rc    <= 1'b0;
      od_match_pending <= 1'b0;
      selected_o   <= 1'b0;
      data_o       <= 8'h00;
      data_valid_o <= 1'b0;
    end else begin
      data_valid_o <= 1'b0;
      if (reset_seen) begin
        state <= ST_CMD;
        bitn  <= 7'd0;
        selected_o <= 1'b0;
        od_match_pending <= 1'b0;
        if (long_reset) od <= 1'b0;
      end else if (bit_done) begin
        case (state)
          ST_CMD: begin
            shreg <= cmd_next;
            bitn  <= bitn + 7'd1;
            if (bitn == 7'd7) begin
              bitn  <= 7'd0;
              phase <= 2'd0;
              case (cmd_next)
                CMD_READ:   state <= ST_READ_ID;
                CMD_MATCH:  begin
                  state <= ST_MATCH;
                  rc    <= 1'b0;
                end
                CMD_OD_MATCH: begin
                  state <= ST_MATCH;
                  rc    <= 1'b0;
                  od_match_pending <= 1'b1;
                  od    <= 1'b1; // identity follows at fast speed
                end
                CMD_SEARCH: begin
                  state <= ST_SEARCH;
                  rc    <= 1'b0;
                end
                CMD_SKIP: begin
                  state <= ST_SELECTED;
                  rc    <= 1'b0;
                end
                CMD_OD_SKIP: begin
                  state <= ST_SELECTED;
                  od    <= 1'b1;
                  rc    <= 1'b0;
                end
                CMD_RESUME: state <= rc ? ST_SELECTED : ST_PASSIVE;
                default:    state <= ST_PASSIVE;
              endcase
            end
          end
          ST_READ_ID: begin
            bitn <= bitn + 7'd1;
            if (bitn == 7'(ID_BITS - 1)) state <= ST_SELECTED;
          end
          ST_MATCH: begin
            bitn <= bitn + 7'd1;
            if (bit_val != IDENTITY[bitn[5:0]]) begin
              state <= ST_PASSIVE;
              // keeps fast speed only if it was already fast before
              if (od_match_pending && !overdrive_o) od <= 1'b0;
            end else if (bitn == 7'(ID_BITS - 1)) begin
              state <= ST_SELECTED;
              rc    <= 1'b1;
            end
          end
          ST_SEARCH: begin
            phase <= (phase == 2'd2) ? 2'd0 : phase + 2'd1;
            if (phase == 2'd2) begin
              bitn <= bitn + 7'd1;
              if (bit_val != IDENTITY[bitn[5:0]]) begin
                state <= ST_PASSIVE;
              end else if (bitn == 7'(ID_BITS - 1)) begin
                state <= ST_SELECTED;
                rc    <= 1'b1;
              end
            end
          end
          ST_SELECTED: begin
            shreg <= cmd_next;
            bitn  <= bitn + 7'd1;
            if (bitn[2:0] == 3'd7) begin
              data_o       <= cmd_next;
              data_valid_o <= 1'b1;
            end
          end
          default: state <= state;
        endcase
        if (state == ST_MATCH || state == ST_SEARCH) selected_o <= 1'b0;
      end else if (state == ST_SELECTED) begin
        selected_o <= 1'b1;
      end
    end
  end

  // speed seen before a pending overdrive-match
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      overdrive_o <= 1'b0;
      resume_o    <= 1'b0;
    end else begin
      if (!od_match_pending) overdrive_o <= od;
      else if (state == ST_SELECTED) overdrive_o <= 1'b1;
      resume_o <= rc;
    end
  end
endmodule

// ===== swr_master.sv
// master end: issues reset, write and read slots
`timescale 1ns/1ps
module swr_master
  import swr_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic srst_i,
  swr_if.master     bus,
  input  wire logic req_valid_i,
  input  swr_pkg::swr_req_t req_i,
  input  wire logic fast_i,
  output logic      busy_o,
  output logic      done_o,
  output logic      rx_bit_o,
  output logic      presence_o
);
  import swr_pkg::*;
  logic [CNT_W-1:0] tmr;
  logic [CNT_W-1:0] low_len;
  logic [CNT_W-1:0] end_t;
  logic             is_rst;
  logic             fast;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      rx_bit_o   <= 1'b0;
      presence_o <= 1'b0;
      tmr     <= '0;
      low_len <= '0;
      end_t   <= '0;
      is_rst  <= 1'b0;
      fast    <= 1'b0;
      bus.mst_line_o  <= 1'b0;
      bus.mst_line_oe <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!busy_o) begin
        if (req_valid_i) begin
          busy_o <= 1'b1;
          tmr    <= '0;
          fast   <= fast_i;
          is_rst <= (req_i == SWR_REQ_RESET);
          bus.mst_line_oe <= 1'b1;
          case (req_i)
            SWR_REQ_RESET: begin
              low_len <= CNT_W'(fast_i ? RSTLOW_OD_CYC : RSTLOW_STD_CYC);
              end_t   <= CNT_W'(fast_i ? 2 * RSTLOW_OD_CYC : 2 * RSTLOW_STD_CYC);
            end
            SWR_REQ_WRITE0: begin
              low_len <= CNT_W'(fast_i ? W0_OD_CYC : W0_STD_CYC);
              end_t   <= CNT_W'(fast_i ? W0_OD_CYC + REC_OD_CYC : W0_STD_CYC + REC_STD_CYC);
            end
            default: begin
              low_len <= CNT_W'(fast_i ? W1_OD_CYC : W1_STD_CYC);
              end_t   <= CNT_W'(fast_i ? SLOT_OD_CYC + REC_OD_CYC : SLOT_STD_CYC + REC_STD_CYC);
            end
          endcase
          presence_o <= 1'b0;
        end
      end else begin
        tmr <= tmr + 1'b1;
        if (tmr == low_len) bus.mst_line_oe <= 1'b0;
        // read window sample, late enough to see a released one
        if (!is_rst && tmr == low_len + CNT_W'(fast ? 1 : 20)) rx_bit_o <= bus.line;
        if (is_rst && tmr > low_len + CNT_W'(HOLDOFF_CYC + 1) && !bus.line) presence_o <= 1'b1;
        if (tmr == end_t) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== swr_asserts.sv
// wire-level checks on the link between the device and master ends
`timescale 1ns/1ps
module swr_asserts
  import swr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic dev_line_o,
  input wire logic dev_line_oe,
  input wire logic mst_line_o,
  input wire logic mst_line_oe,
  input wire logic line
);
  logic [15:0] hi_cnt;
  logic [15:0] mst_cnt;
  logic [15:0] dev_cnt;
  logic        mst_oe_q;
  logic        pres_pend;
  logic [15:0] pres_cnt;
  ////////////////////////////////////////////////////////////////////////////
  // line starts idle high, so the high counter starts saturated
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !line) begin
      hi_cnt <= srst_i ? 16'hFFFF : 16'h0000;
    end else if (hi_cnt != 16'hFFFF) begin
      hi_cnt <= hi_cnt + 16'h0001;
    end
  end
  always_ff @(posedge core_clk_i) begin
    mst_cnt <= (srst_i || !mst_line_oe) ? 16'h0000 : mst_cnt + 16'h0001;
  end
  always_ff @(posedge core_clk_i) begin
    dev_cnt <= (srst_i || !dev_line_oe) ? 16'h0000 : dev_cnt + 16'h0001;
  end
  // cycles from the end of a reset-length master pull to the presence pull
  always_ff @(posedge core_clk_i) begin
    mst_oe_q <= mst_line_oe;
    if (srst_i) begin
      pres_pend <= 1'b0;
      pres_cnt  <= 16'h0000;
    end else if (mst_oe_q && !mst_line_oe && mst_cnt >= 16'(RSTLOW_OD_CYC - 1)) begin
      pres_pend <= 1'b1;
      pres_cnt  <= 16'h0000;
    end else if (dev_line_oe) begin
      pres_pend <= 1'b0;
    end else if (pres_pend && pres_cnt != 16'hFFFF) begin
      pres_cnt <= pres_cnt + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_mst_pull_end;
    $fell(mst_line_oe);
  endsequence
  sequence s_dev_pull_end;
    $fell(dev_line_oe);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_dev_pull_only: assert property (dev_line_oe |-> !dev_line_o)
    else $error("device drives the line high");
  chk_mst_pull_only: assert property (mst_line_oe |-> !mst_line_o)
    else $error("master drives the line high");
  chk_dev_no_fall: assert property ($rose(dev_line_oe) |-> !$past(line) || hi_cnt >= 16'h00C8)
    else $error("device started a low on an idle line outside presence");
  chk_dev_pull_len: assert property (s_dev_pull_end |-> $past(dev_cnt) inside
    {[READ_LOW_OD_CYC-20:READ_LOW_OD_CYC+1], [READ_LOW_STD_CYC-20:READ_LOW_STD_CYC+1],
     [PRES_LOW_OD_CYC-2:PRES_LOW_OD_CYC+1], [PRES_LOW_STD_CYC-2:PRES_LOW_STD_CYC+1]})
    else $error("device pull length off");
  chk_mst_pull_len: assert property (s_mst_pull_end |-> $past(mst_cnt) inside
    {[W1_OD_CYC-2:W1_OD_CYC+1], [W1_STD_CYC-2:W1_STD_CYC+1], [W0_OD_CYC-2:W0_OD_CYC+1],
     [W0_STD_CYC-2:W0_STD_CYC+1], [RSTLOW_OD_CYC-2:RSTLOW_OD_CYC+1], [RSTLOW_STD_CYC-2:RSTLOW_STD_CYC+1]})
    else $error("master pull length off");
  chk_slot_recovery: assert property ($rose(mst_line_oe) |-> $past(hi_cnt) >= 16'(REC_OD_CYC))
    else $error("slot started without recovery time");
  chk_presence_due: assert property (pres_pend |-> pres_cnt < 16'h0C1C)
    else $error("no presence pulse after reset pulse");
  chk_presence_early: assert property (pres_pend && dev_line_oe |-> pres_cnt >= 16'h00F9)
    else $error("presence pulse started too soon after reset pulse");
  chk_slot_after_dev: assert property ($rose(mst_line_oe) |-> !$past(dev_line_oe))
    else $error("master slot started while device still pulls");
  chk_dev_pull_bound: assert property (dev_line_oe |-> dev_cnt <= 16'(PRES_LOW_STD_CYC + 1))
    else $error("device holds the line too long");
endmodule

// ===== testbench.sv
// self-checking bench joining the device and master ends over the link
`timescale 1ns/1ps
module testbench;
  import swr_pkg::*;
  typedef struct packed {
    logic [7:0] cmd;
    logic       sel;
    logic       res;
    logic       od;
  } swr_row_t;
  localparam logic [63:0] OWN_ID = 64'h0123_4567_89AB_CD10; // arbitrary value
  logic        core_clk_i;
  logic        srst_i;
  logic        req_valid_i;
  swr_req_t    req_i;
  logic        fast_i;
  logic        selected_o;
  logic        overdrive_o;
  logic        resume_o;
  logic [7:0]  data_o;
  logic        data_valid_o;
  logic        busy_o;
  logic        done_o;
  logic        rx_bit_o;
  logic        presence_o;
  logic [63:0] got;
  int          errors;
  int          compares;
  int          dv_cnt;
  swr_row_t    rows [4];
  ////////////////////////////////////////////////////////////////////////////
  swr_if u_swr_if ();
  swr_device #(.IDENTITY(OWN_ID)) u_swr_device (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus(u_swr_if),
    .selected_o(selected_o), .overdrive_o(overdrive_o), .resume_o(resume_o), .data_o(data_o),
    .data_valid_o(data_valid_o));
  swr_master u_swr_master (.core_clk_i(core_clk_i), .srst_i(srst_i), .bus(u_swr_if), .req_valid_i(req_valid_i),
    .req_i(req_i), .fast_i(fast_i), .busy_o(busy_o), .done_o(done_o), .rx_bit_o(rx_bit_o),
    .presence_o(presence_o));
  swr_asserts u_swr_asserts (.core_clk_i(core_clk_i), .srst_i(srst_i), .dev_line_o(u_swr_if.dev_line_o),
    .dev_line_oe(u_swr_if.dev_line_oe), .mst_line_o(u_swr_if.mst_line_o),
    .mst_line_oe(u_swr_if.mst_line_oe), .line(u_swr_if.line));
  ////////////////////////////////////////////////////////////////////////////
  always #5 core_clk_i = ~core_clk_i;
  // counts delivered bytes, the valid strobe stands for one cycle only
  always @(posedge core_clk_i) begin
    if (data_valid_o === 1'b1) begin
      dv_cnt++;
    end
  end
  task automatic check(input logic [63:0] act, input logic [63:0] exp);
    compares++;
    if (act !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  // one master request, then wait for its completion pulse
  task automatic slot(input swr_req_t r);
    int n;
    n = 0;
    @(posedge core_clk_i);
    req_valid_i <= 1'b1;
    req_i <= r;
    @(posedge core_clk_i);
    req_valid_i <= 1'b0;
    @(negedge core_clk_i);
    while (done_o !== 1'b1 && n < 120000) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 120000) begin
      check(64'h0, 64'h1);
      print_verdict();
    end
  endtask
  task automatic bus_reset();
    slot(SWR_REQ_RESET);
    check(64'(presence_o), 64'h1);
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      slot(b[i] ? SWR_REQ_WRITE1 : SWR_REQ_WRITE0);
    end
  endtask
  task automatic send_id(input logic [63:0] v);
    for (int i = 0; i < 64; i++) begin
      slot(v[i] ? SWR_REQ_WRITE1 : SWR_REQ_WRITE0);
    end
  endtask
  task automatic read_bit(input logic exp);
    slot(SWR_REQ_READ);
    check(64'(rx_bit_o), 64'(exp));
  endtask
  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (1500000) @(posedge core_clk_i);
    errors++;
    print_verdict();
  end
  initial begin
    core_clk_i = 1'b0;
    srst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = SWR_REQ_RESET;
    fast_i = 1'b0;
    errors = 0;
    compares = 0;
    dv_cnt = 0;
    rows = '{'{CMD_SKIP, 1'b1, 1'b0, 1'b1}, '{CMD_RESUME, 1'b0, 1'b0, 1'b1},
             '{8'h5A, 1'b0, 1'b0, 1'b1}, '{CMD_OD_SKIP, 1'b1, 1'b0, 1'b1}};
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(negedge core_clk_i);
    check(64'({selected_o, overdrive_o, resume_o, busy_o, presence_o}), 64'h0);
    bus_reset();
    send_byte(CMD_OD_SKIP);
    check(64'({selected_o, overdrive_o}), 64'h3);
    @(posedge core_clk_i);
    fast_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus_reset();
      send_byte(rows[i].cmd);
      check(64'({selected_o, resume_o, overdrive_o}), 64'({rows[i].sel, rows[i].res, rows[i].od}));
      if (!rows[i].sel) begin
        read_bit(1'b1);
      end
    end
    bus_reset();
    send_byte(CMD_READ);
    for (int i = 0; i < 64; i++) begin
      slot(SWR_REQ_READ);
      got[i] = rx_bit_o;
    end
    check(got, OWN_ID);
    bus_reset();
    send_byte(CMD_MATCH);
    send_id(OWN_ID);
    check(64'({selected_o, resume_o}), 64'h3);
    send_byte(8'hA6);
    check(64'(data_o), 64'hA6);
    check(64'(dv_cnt), 64'h1);
    for (int k = 0; k < 2; k++) begin
      bus_reset();
      send_byte(CMD_RESUME);
      check(64'(selected_o), 64'h1);
    end
    bus_reset();
    send_byte(CMD_MATCH);
    slot(OWN_ID[0] ? SWR_REQ_WRITE0 : SWR_REQ_WRITE1);
    read_bit(1'b1);
    check(64'({selected_o, resume_o}), 64'h0);
    bus_reset();
    send_byte(CMD_RESUME);
    check(64'(selected_o), 64'h0);
    bus_reset();
    send_byte(CMD_OD_MATCH);
    slot(OWN_ID[0] ? SWR_REQ_WRITE0 : SWR_REQ_WRITE1);
    check(64'({selected_o, overdrive_o}), 64'h1);
    bus_reset();
    send_byte(CMD_OD_MATCH);
    send_id(OWN_ID);
    check(64'({selected_o, resume_o, overdrive_o}), 64'h7);
    bus_reset();
    send_byte(CMD_SEARCH);
    check(64'(resume_o), 64'h0);
    read_bit(OWN_ID[0]);
    read_bit(!OWN_ID[0]);
    slot(OWN_ID[0] ? SWR_REQ_WRITE0 : SWR_REQ_WRITE1);
    read_bit(1'b1);
    @(posedge core_clk_i);
    fast_i <= 1'b0;
    bus_reset();
    check(64'(overdrive_o), 64'h0);
    print_verdict();
  end
endmodule
